// ==== inc/byte_alu_consts.svh ====
// byte alu constants: register offsets, field positions, reset values
// assumes a 10-bit byte address on the register port, 32-bit data
`ifndef BYTE_ALU_CONSTS_SVH
`define BYTE_ALU_CONSTS_SVH

// register offsets (byte addresses, one word each)
`define OFF_WORK        10'h000
`define OFF_STATUS      10'h004
`define OFF_CMD         10'h008
`define OFF_RESULT      10'h00C
// file register window: base + 4 * index
`define FILE_WIN_BIT    9

// command word fields
`define CMD_OP_LSB      0
`define CMD_DEST_BIT    2
`define CMD_FADDR_LSB   8
`define CMD_LIT_LSB     16

// status word fields
`define ST_CARRY_BIT    0
`define ST_DIGIT_BIT    1
`define ST_ZERO_BIT     2
`define ST_BUSY_BIT     7

// reset values
`define WORK_RST        8'h00
`define RESULT_RST      8'h00

`endif

// ==== inc/byte_alu_pkg.sv ====
// byte alu types: operations, sequencer states, command and flag carriers
// assumes nothing beyond a SystemVerilog compiler
package byte_alu_pkg;

  typedef enum logic [1:0] {
    OP_SUB_WORK_FROM_FILE = 2'h0,
    OP_SWAP_NIBBLES_FILE  = 2'h1,
    OP_XOR_LITERAL_WORK   = 2'h2,
    OP_XOR_WORK_FILE      = 2'h3
  } alu_op_t;

  typedef enum logic [1:0] {
    SEQ_IDLE = 2'b00,
    SEQ_LOAD = 2'b01,
    SEQ_EXEC = 2'b10
  } seq_state_t;

  typedef struct packed {
    logic [7:0] literal;
    logic [6:0] faddr;
    logic       dest;
    alu_op_t    op;
  } alu_cmd_t;

  typedef struct packed {
    logic zero;
    logic digit_carry_flag;
    logic carry;
  } alu_flags_t;

  typedef struct packed {
    logic [7:0] value;
    alu_flags_t flags;
    logic       upd_carry;
    logic       upd_digit;
    logic       upd_zero;
    logic       to_file;
  } alu_result_t;

endpackage

// ==== design/file_ram.sv ====
// file register storage: one write port, two registered read ports
// assumes one clock; reads return the word addressed in the previous cycle
`timescale 1ns/1ps

module file_ram #(
  parameter int DEPTH = 128,
  parameter int AW    = 7
) (
  input  wire logic          i_clk,
  input  wire logic          i_rst,
  input  wire logic          i_ce,
  input  wire logic          i_we,
  input  wire logic [AW-1:0] i_waddr,
  input  wire logic [7:0]    i_wdata,
  input  wire logic [AW-1:0] i_raddr_a,
  output logic      [7:0]    o_rdata_a,
  input  wire logic [AW-1:0] i_raddr_b,
  output logic      [7:0]    o_rdata_b
);

  logic [7:0] mem [DEPTH];

  generate
    if (DEPTH != (1 << AW)) begin : g_bad_depth
      $error("file_ram: DEPTH must equal 2**AW");
    end
  endgenerate

  always_ff @(posedge i_clk) begin
    if (i_ce && i_we) begin
      mem[i_waddr] <= i_wdata;
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      o_rdata_a <= 8'h00;
      o_rdata_b <= 8'h00;
    end else if (i_ce) begin
      o_rdata_a <= mem[i_raddr_a];
      o_rdata_b <= mem[i_raddr_b];
    end
  end

endmodule // file_ram

// ==== design/byte_alu_sub_swap_xor.sv ====
// byte datapath: subtract, nibble swap and exclusive-or on a work register
// and a file register store, driven over a plain register port
// assumes strobes from logic on i_clk, one strobe per cycle at most
`timescale 1ns/1ps
`include "byte_alu_consts.svh"

module byte_alu_sub_swap_xor
  import byte_alu_pkg::*;
#(
  parameter int FILE_DEPTH = 128
) (
  input  wire logic        i_clk,
  input  wire logic        i_rst,
  input  wire logic        i_ce,
  input  wire logic [9:0]  i_addr,
  input  wire logic [31:0] i_wdata,
  input  wire logic        i_wr,
  input  wire logic        i_rd,
  output logic      [31:0] o_rdata,
  output logic             o_busy,
  output logic             o_done,
  output logic      [7:0]  o_work,
  output alu_flags_t       o_flags
);

  localparam int FA_W = $clog2(FILE_DEPTH);

  generate
    if (FILE_DEPTH < 2 || FILE_DEPTH > 128 ||
        (FILE_DEPTH & (FILE_DEPTH - 1)) != 0) begin : g_bad_depth
      $error("FILE_DEPTH must be a power of two from 2 to 128");
    end
  endgenerate

  ////////////////////////////////////////////////////////////////////////////
  // functions

  function automatic logic is_zero(input logic [7:0] v);
    is_zero = (v == 8'h00);
  endfunction

  function automatic alu_cmd_t unpack_cmd(input logic [31:0] w);
    alu_cmd_t c;
    c.op      = alu_op_t'(w[`CMD_OP_LSB +: 2]);
    c.dest    = w[`CMD_DEST_BIT];
    c.faddr   = w[`CMD_FADDR_LSB +: 7];
    c.literal = w[`CMD_LIT_LSB +: 8];
    unpack_cmd = c;
  endfunction

  function automatic logic [31:0] pack_cmd(input alu_cmd_t c);
    logic [31:0] w;
    w = 32'h0000_0000;
    w[`CMD_OP_LSB +: 2]   = c.op;
    w[`CMD_DEST_BIT]      = c.dest;
    w[`CMD_FADDR_LSB +: 7] = c.faddr;
    w[`CMD_LIT_LSB +: 8]  = c.literal;
    pack_cmd = w;
  endfunction

  function automatic logic [31:0] pack_status(input alu_flags_t f,
                                              input logic busy);
    logic [31:0] w;
    w = 32'h0000_0000;
    w[`ST_CARRY_BIT] = f.carry;
    w[`ST_DIGIT_BIT] = f.digit_carry_flag;
    w[`ST_ZERO_BIT]  = f.zero;
    w[`ST_BUSY_BIT]  = busy;
    pack_status = w;
  endfunction

  // one operation on work, file byte and literal
  function automatic alu_result_t compute(input alu_cmd_t   c,
                                          input logic [7:0] work,
                                          input logic [7:0] file);
    alu_result_t r;
    logic [8:0]  diff;
    logic [4:0]  ndiff;
    diff  = {1'b0, file} + {1'b0, ~work} + 9'h001;
    ndiff = {1'b0, file[3:0]} + {1'b0, ~work[3:0]} + 5'h01;
    r = '0;
    r.to_file = c.dest;
    unique case (c.op)
      OP_SUB_WORK_FROM_FILE: begin
        r.value                  = diff[7:0];
        r.flags.carry            = diff[8];
        r.flags.digit_carry_flag = ndiff[4];
        r.upd_carry              = 1'b1;
        r.upd_digit              = 1'b1;
        r.upd_zero               = 1'b1;
      end
      OP_SWAP_NIBBLES_FILE: begin
        r.value = {file[3:0], file[7:4]};
      end
      OP_XOR_LITERAL_WORK: begin
        r.value    = work ^ c.literal;
        r.upd_zero = 1'b1;
        r.to_file  = 1'b0;
      end
      OP_XOR_WORK_FILE: begin
        r.value    = work ^ file;
        r.upd_zero = 1'b1;
      end
    endcase
    r.flags.zero = is_zero(r.value);
    compute = r;
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // state

  seq_state_t  state_reg;
  seq_state_t  state_next;
  alu_cmd_t    cmd_reg;
  alu_flags_t  flags_reg;
  logic [7:0]  work_reg;
  logic [7:0]  result_reg;
  logic        busy_reg;
  logic        done_reg;
  logic [31:0] rdata_reg;
  logic        file_rd_reg;

  ////////////////////////////////////////////////////////////////////////////
  // address decode

  wire        hit_work   = (i_addr == `OFF_WORK);
  wire        hit_status = (i_addr == `OFF_STATUS);
  wire        hit_cmd    = (i_addr == `OFF_CMD);
  wire        hit_result = (i_addr == `OFF_RESULT);
  wire [6:0]  bus_word   = i_addr[8:2];
  wire        hit_file   = i_addr[`FILE_WIN_BIT] &&
                           (i_addr[1:0] == 2'h0) &&
                           (32'(bus_word) < FILE_DEPTH);

  // writes are refused while an operation runs
  wire        wr_ok      = i_wr && !busy_reg;
  wire        wr_work    = wr_ok && hit_work;
  wire        wr_status  = wr_ok && hit_status;
  wire        wr_cmd     = wr_ok && hit_cmd;
  wire        wr_file    = wr_ok && hit_file;

  wire [31:0] reg_rd_data =
      hit_work   ? {24'h000000, work_reg}   :
      hit_status ? pack_status(flags_reg, busy_reg) :
      hit_cmd    ? pack_cmd(cmd_reg)        :
      hit_result ? {24'h000000, result_reg} :
                   32'h0000_0000;

  ////////////////////////////////////////////////////////////////////////////
  // file register store

  wire              exec       = (state_reg == SEQ_EXEC);
  wire [7:0]        file_a;
  wire [7:0]        file_b;
  wire alu_result_t res        = compute(cmd_reg, work_reg, file_b);
  wire              exec_file  = exec && res.to_file;
  wire              ram_we     = exec_file || wr_file;
  wire [FA_W-1:0]   ram_waddr  = exec_file ? cmd_reg.faddr[FA_W-1:0]
                                           : bus_word[FA_W-1:0];
  wire [7:0]        ram_wdata  = exec_file ? res.value : i_wdata[7:0];

  file_ram #(
    .DEPTH (FILE_DEPTH),
    .AW    (FA_W)
  ) u_file_ram (
    .i_clk     (i_clk),
    .i_rst     (i_rst),
    .i_ce      (i_ce),
    .i_we      (ram_we),
    .i_waddr   (ram_waddr),
    .i_wdata   (ram_wdata),
    .i_raddr_a (bus_word[FA_W-1:0]),
    .o_rdata_a (file_a),
    .i_raddr_b (cmd_reg.faddr[FA_W-1:0]),
    .o_rdata_b (file_b)
  );

  ////////////////////////////////////////////////////////////////////////////
  // sequencer: idle, load the file byte, execute

  always_comb begin
    state_next = state_reg;
    unique case (state_reg)
      SEQ_IDLE: begin
        if (wr_cmd) begin
          state_next = SEQ_LOAD;
        end
      end
      SEQ_LOAD: begin
        state_next = SEQ_EXEC;
      end
      SEQ_EXEC: begin
        state_next = SEQ_IDLE;
      end
      default: begin
        state_next = SEQ_IDLE;
      end
    endcase
  end

  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      state_reg <= SEQ_IDLE;
      busy_reg  <= 1'b0;
      done_reg  <= 1'b0;
    end else if (i_ce) begin
      state_reg <= state_next;
      busy_reg  <= (state_next != SEQ_IDLE);
      done_reg  <= exec;
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      cmd_reg <= '0;
    end else if (i_ce && wr_cmd) begin
      cmd_reg <= unpack_cmd(i_wdata);
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // work register and result

  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      work_reg <= `WORK_RST;
    end else if (i_ce) begin
      if (exec && !res.to_file) begin
        work_reg <= res.value;
      end else if (wr_work) begin
        work_reg <= i_wdata[7:0];
      end
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      result_reg <= `RESULT_RST;
    end else if (i_ce && exec) begin
      result_reg <= res.value;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // status flags: each op touches only its own flags

  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      flags_reg <= '0;
    end else if (i_ce) begin
      if (exec) begin
        if (res.upd_carry) begin
          flags_reg.carry <= res.flags.carry;
        end
        if (res.upd_digit) begin
          flags_reg.digit_carry_flag <= res.flags.digit_carry_flag;
        end
        if (res.upd_zero) begin
          flags_reg.zero <= res.flags.zero;
        end
      end else if (wr_status) begin
        flags_reg.carry            <= i_wdata[`ST_CARRY_BIT];
        flags_reg.digit_carry_flag <= i_wdata[`ST_DIGIT_BIT];
        flags_reg.zero             <= i_wdata[`ST_ZERO_BIT];
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // read port: data stand only in the cycle after the strobe

  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      rdata_reg   <= 32'h0000_0000;
      file_rd_reg <= 1'b0;
    end else if (i_ce) begin
      rdata_reg   <= i_rd ? reg_rd_data : 32'h0000_0000;
      file_rd_reg <= i_rd && hit_file;
    end
  end

  // file reads come from the store's own read register
  assign o_rdata = file_rd_reg ? {24'h000000, file_a} : rdata_reg;
  assign o_busy  = busy_reg;
  assign o_done  = done_reg;
  assign o_work  = work_reg;
  assign o_flags = flags_reg;

endmodule // byte_alu_sub_swap_xor

// ==== bench/byte_alu_sub_swap_xor_asserts.sv ====
// checker for byte_alu_sub_swap_xor: operation timing, routing and flag updates
// assumes i_ce stays high while an operation runs
`timescale 1ns/1ps
`include "byte_alu_consts.svh"

module byte_alu_sub_swap_xor_chk
  import byte_alu_pkg::*;
(
  input wire logic        i_clk,
  input wire logic        i_rst,
  input wire logic        i_ce,
  input wire logic [9:0]  i_addr,
  input wire logic [31:0] i_wdata,
  input wire logic        i_wr,
  input wire logic        i_rd,
  input wire logic [31:0] o_rdata,
  input wire logic        o_busy,
  input wire logic        o_done,
  input wire logic [7:0]  o_work,
  input wire alu_flags_t  o_flags
);
  default clocking cb @(posedge i_clk);
  endclocking
  default disable iff (i_rst);

  ////////////////////////////////////////////////////////////////////////////////
  wire       cmd_go   = i_ce && i_wr && !o_busy && (i_addr == `OFF_CMD);
  wire [1:0] cmd_op   = i_wdata[1:0];
  wire       cmd_dest = i_wdata[2];
  wire [7:0] cmd_lit  = i_wdata[23:16];
  wire       go_sub   = cmd_go && (cmd_op == 2'h0);
  wire       go_swap  = cmd_go && (cmd_op == 2'h1);
  wire       go_xlit  = cmd_go && (cmd_op == 2'h2);
  wire       go_xf    = cmd_go && (cmd_op == 2'h3);
  // work kept when the result goes to the file store
  wire       go_keepw = cmd_go && cmd_dest && (cmd_op != 2'h2);
  wire       go_zw    = cmd_go && (cmd_op != 2'h1) && (!cmd_dest || cmd_op == 2'h2);
  wire       res_zero = (o_work == 8'h00);
  wire [1:0] cd_flags = o_flags[1:0];

  ////////////////////////////////////////////////////////////////////////////////
  chk_op_timing: assert property (cmd_go |=> o_busy ##1 o_busy ##1 (!o_busy && o_done))
    else $error("operation timing wrong");
  chk_xorlit_work: assert property (
    o_done && $past(go_xlit, 3) |-> o_work == ($past(cmd_lit, 3) ^ $past(o_work, 3)))
    else $error("literal xor result wrong");
  chk_xorlit_flags: assert property (
    o_done && $past(go_xlit, 3) |-> cd_flags == $past(cd_flags, 3))
    else $error("literal xor touched carry flags");
  chk_swap_flags: assert property (
    o_done && $past(go_swap, 3) |-> o_flags == $past(o_flags, 3))
    else $error("swap changed flags");
  chk_dest_file: assert property (
    o_done && $past(go_keepw, 3) |-> o_work == $past(o_work, 3))
    else $error("work changed on file destination");
  chk_xorfile_flags: assert property (
    o_done && $past(go_xf, 3) |-> cd_flags == $past(cd_flags, 3))
    else $error("file xor touched carry flags");
  chk_zero_update: assert property (
    o_done && $past(go_zw, 3) |-> o_flags.zero == res_zero)
    else $error("zero flag disagrees with result");

  cover property (go_sub ##3 !o_flags.carry);
  cover property (go_swap && cmd_dest);
  cover property (go_xlit ##3 o_flags.zero);
endmodule // byte_alu_sub_swap_xor_chk

bind byte_alu_sub_swap_xor byte_alu_sub_swap_xor_chk byte_alu_sub_swap_xor_chk_i (
  .i_clk(i_clk), .i_rst(i_rst), .i_ce(i_ce), .i_addr(i_addr), .i_wdata(i_wdata),
  .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata), .o_busy(o_busy), .o_done(o_done),
  .o_work(o_work), .o_flags(o_flags)
);

// ==== bench/test_byte_alu_sub_swap_xor.sv ====
// testbench for byte_alu_sub_swap_xor: register port driven directly
// assumes the checker is bound in by its own file
`timescale 1ns/1ps
`include "byte_alu_consts.svh"

module test_byte_alu_sub_swap_xor
  import byte_alu_pkg::*;
;
  logic        i_clk, i_rst, i_ce, i_wr, i_rd;
  logic [9:0]  i_addr;
  logic [31:0] i_wdata, o_rdata, rv;
  logic        o_busy, o_done;
  logic [7:0]  o_work;
  alu_flags_t  o_flags;
  int          miscompares, cmp_count;

  byte_alu_sub_swap_xor #(.FILE_DEPTH(128)) byte_alu_sub_swap_xor_i (
    .i_clk(i_clk), .i_rst(i_rst), .i_ce(i_ce), .i_addr(i_addr), .i_wdata(i_wdata),
    .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata), .o_busy(o_busy), .o_done(o_done),
    .o_work(o_work), .o_flags(o_flags)
  );

  initial begin
    i_clk = 1'b0;
    forever #50 i_clk = ~i_clk;
  end

  ////////////////////////////////////////////////////////////////////////////////
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      miscompares++;
      $display("ERROR %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic end_sim();
    $display("comparisons %0d mismatches %0d", cmp_count, miscompares);
    if (miscompares == 0 && cmp_count > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask

  function automatic logic [9:0] fa(input logic [6:0] n);
    return {1'b1, n, 2'h0};
  endfunction

  task automatic wr(input logic [9:0] a, input logic [31:0] d);
    @(posedge i_clk);
    i_wr    <= 1'b1;
    i_addr  <= a;
    i_wdata <= d;
    @(posedge i_clk);
    i_wr <= 1'b0;
  endtask

  task automatic rd(input logic [9:0] a, output logic [31:0] d);
    @(posedge i_clk);
    i_rd   <= 1'b1;
    i_addr <= a;
    @(posedge i_clk);
    i_rd <= 1'b0;
    #1 d = o_rdata;
  endtask

  // bounded wait for the completion pulse, returns cycles waited
  task automatic wait_done(output int k);
    k = 0;
    while (o_done !== 1'b1) begin
      @(posedge i_clk);
      #1;
      k++;
      if (k > 8) begin
        miscompares++;
        end_sim();
      end
    end
  endtask

  task automatic run_op(input logic [1:0] op, input logic dest, input logic [6:0] n,
                        input logic [7:0] f, input logic [7:0] w, input logic [7:0] lit,
                        input logic [2:0] pre, input logic [7:0] exp,
                        input logic [2:0] eflg);
    int   lat;
    logic to_file;
    to_file = dest && (op != 2'h2);
    wr(fa(n), {24'h0, f});
    wr(`OFF_WORK, {24'h0, w});
    wr(`OFF_STATUS, {29'h0, pre});
    wr(`OFF_CMD, {8'h00, lit, 1'b0, n, 5'h00, dest, op});
    wait_done(lat);
    chk(32'(lat), 32'h2);
    chk({24'h0, o_work}, {24'h0, to_file ? w : exp});
    chk({29'h0, o_flags}, {29'h0, eflg});
    rd(fa(n), rv);
    chk(rv, {24'h0, to_file ? exp : f});
    rd(`OFF_RESULT, rv);
    chk(rv, {24'h0, exp});
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  task automatic t_reset();
    chk({18'h0, o_busy, o_done, o_work, 1'b0, o_flags}, 32'h0);
    for (int i = 0; i < 5; i++) begin
      rd(10'(4 * i), rv);
      chk(rv, 32'h0);
    end
    $display("test reset done");
  endtask

  task automatic t_sub();
    logic [7:0] f [4] = '{8'h50, 8'h30, 8'h25, 8'h10};
    logic [7:0] w [4] = '{8'h30, 8'h50, 8'h25, 8'h01};
    logic [7:0] d;
    logic [2:0] g;
    for (int i = 0; i < 4; i++) begin
      d = f[i] - w[i];
      g = {d == 8'h00, f[i][3:0] >= w[i][3:0], f[i] >= w[i]};
      run_op(2'h0, i[0], 7'(i + 8), f[i], w[i], 8'h00, ~g, d, g);
    end
    $display("test sub done");
  endtask

  task automatic t_swap();
    run_op(2'h1, 1'b0, 7'h05, 8'hA7, 8'h3C, 8'h00, 3'h7, 8'h7A, 3'h7);
    run_op(2'h1, 1'b1, 7'h7F, 8'h0F, 8'h11, 8'h00, 3'h2, 8'hF0, 3'h2);
    $display("test swap done");
  endtask

  task automatic t_xor();
    run_op(2'h2, 1'b0, 7'h01, 8'h99, 8'h5A, 8'h5A, 3'h3, 8'h00, 3'h7);
    run_op(2'h2, 1'b1, 7'h02, 8'h99, 8'h00, 8'hFF, 3'h4, 8'hFF, 3'h0);
    run_op(2'h3, 1'b0, 7'h03, 8'hC3, 8'h3C, 8'h00, 3'h1, 8'hFF, 3'h1);
    run_op(2'h3, 1'b1, 7'h04, 8'h66, 8'h66, 8'h55, 3'h2, 8'h00, 3'h6);
    $display("test xor done");
  endtask

  // writes while busy, with clock enable low, and to a hole are all dropped
  task automatic t_refuse();
    wr(`OFF_WORK, 32'h11);
    wr(`OFF_CMD, {8'h00, 8'h0F, 16'h0002});
    #1;
    chk({31'h0, o_busy}, 32'h1);
    wr(`OFF_WORK, 32'hEE);
    #1;
    chk({31'h0, o_done}, 32'h1);
    chk({31'h0, o_busy}, 32'h0);
    chk({24'h0, o_work}, 32'h1E);
    @(posedge i_clk);
    i_ce <= 1'b0;
    wr(`OFF_WORK, 32'h77);
    @(posedge i_clk);
    i_ce <= 1'b1;
    wr(10'h010, 32'hFF);
    rd(`OFF_WORK, rv);
    chk(rv, 32'h1E);
    // read data stand for one cycle only
    @(posedge i_clk);
    #1;
    chk(o_rdata, 32'h0);
    rd(`OFF_STATUS, rv);
    chk(rv, 32'h2);
    rd(`OFF_CMD, rv);
    chk(rv, 32'h000F_0002);
    rd(10'h010, rv);
    chk(rv, 32'h0);
    $display("test refuse done");
  endtask

  initial begin
    i_rst       = 1'b1;
    i_ce        = 1'b1;
    i_wr        = 1'b0;
    i_rd        = 1'b0;
    i_addr      = 10'h000;
    i_wdata     = 32'h0;
    miscompares = 0;
    cmp_count   = 0;
    repeat (6) @(posedge i_clk);
    i_rst <= 1'b0;
    @(posedge i_clk);
    #1;
    t_reset();
    t_sub();
    t_swap();
    t_xor();
    t_refuse();
    end_sim();
  end
endmodule // test_byte_alu_sub_swap_xor
